// ===== common/srwp_pkg.sv
// Constants, register map and reset values of the serial register write port
package srwp_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 6;
    localparam int NUM_REGS = 64;
    localparam int LINE_W = 2 * DATA_W;
    localparam logic [4:0] ADDR_LAST_BIT = 5'h09;
    localparam logic [4:0] DATA_LAST_BIT = 5'h05;
    localparam logic [ADDR_W-1:0] A_OPR_LO = 10'h000;
    localparam logic [ADDR_W-1:0] A_OPR_HI = 10'h001;
    localparam logic [ADDR_W-1:0] A_VGA_LO = 10'h002;
    localparam logic [ADDR_W-1:0] A_SWRST = 10'h017;
    localparam logic [ADDR_W-1:0] A_UPD_LO = 10'h019;
    localparam logic [ADDR_W-1:0] A_UPD_HI = 10'h01A;
    localparam logic [ADDR_W-1:0] A_INHIBIT = 10'h01B;
    localparam logic [ADDR_W-1:0] A_TGRST = 10'h029;
    localparam logic [ADDR_W-1:0] A_OSC = 10'h033;
    localparam logic [ADDR_W-1:0] A_SG_FIRST = 10'h03A;
    // Groups: bit n stands for register address n
    localparam logic [NUM_REGS-1:0] STB_MASK = 64'h000E_07FE_1080_0043;
    localparam logic [NUM_REGS-1:0] SG_MASK = 64'hFC00_0000_0000_0000;
    localparam logic [NUM_REGS-1:0] DBL_LO_MASK = 64'h0000_0000_0200_0015;

    function automatic logic [DATA_W-1:0] srwp_default(input logic [ADDR_W-1:0] a);
        case (a)
            10'h000: return 6'h10;
            10'h002: return 6'h05;
            10'h003: return 6'h01;
            10'h005: return 6'h02;
            10'h021: return 6'h01;
            10'h031: return 6'h01;
            10'h032: return 6'h02;
            10'h033: return 6'h01;
            default: return 6'h00;
        endcase
    endfunction
endpackage

// ===== hw/srwp_shift_rx.sv
// Serial-clock side: bit assembly, address auto-increment and word hand-off
`timescale 1ns/1ps
module srwp_shift_rx import srwp_pkg::*; (
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    input wire logic rst_n,
    output logic [ADDR_W-1:0] word_addr_r,
    output logic [DATA_W-1:0] word_data_r,
    output logic word_toggle_r
);
    logic [ADDR_W-1:0] sh_r;
    logic [ADDR_W-1:0] addr_r;
    logic [4:0] cnt_r;
    logic addr_done_r;
    logic word_done;

    assign word_done = addr_done_r && (cnt_r == DATA_LAST_BIT);

    // =========================================================
    // Frame state, cleared by the strobe itself since the serial clock stops
    always_ff @(posedge serial_clock or posedge serial_load_strobe) begin
        if (serial_load_strobe) begin
            sh_r <= '0;
            addr_r <= '0;
            cnt_r <= '0;
            addr_done_r <= 1'b0;
        end else begin
            sh_r <= {serial_data, sh_r[ADDR_W-1:1]};
            if (!addr_done_r) begin
                if (cnt_r == ADDR_LAST_BIT) begin
                    addr_r <= {serial_data, sh_r[ADDR_W-1:1]};
                    addr_done_r <= 1'b1;
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_r + 5'h01;
                end
            end else if (word_done) begin
                addr_r <= addr_r + 10'h001;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // =========================================================
    // Hand-off holds for six serial clocks, ample for the toggle crossing
    always_ff @(posedge serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            word_addr_r <= '0;
            word_data_r <= '0;
            word_toggle_r <= 1'b0;
        end else if (word_done) begin
            word_addr_r <= addr_r;
            word_data_r <= {serial_data, sh_r[ADDR_W-1:ADDR_W-DATA_W+1]};
            word_toggle_r <= !word_toggle_r;
        end
    end

    AST_WORD_ONLY_WHOLE: assert property (@(posedge serial_clock) disable iff (!rst_n)
        (word_toggle_r != $past(word_toggle_r)) |-> $past(cnt_r) == DATA_LAST_BIT)
        else $error("word handed off before six data bits");
    // Frame state is cleared between transfers, so only judge inside one frame
    AST_AUTO_INCREMENT: assert property (@(posedge serial_clock) disable iff (!rst_n || serial_load_strobe)
        (word_toggle_r != $past(word_toggle_r)) && addr_done_r |-> addr_r == word_addr_r + 10'h001)
        else $error("address did not advance by one after a word");
    COV_BURST: cover property (@(posedge serial_clock) disable iff (!rst_n)
        word_done ##6 word_done);
endmodule // srwp_shift_rx

// ===== hw/srwp_top.sv
// Serial register write port: crossing, shadow registers and grouped commit
`timescale 1ns/1ps
// ============================================================
module srwp_top import srwp_pkg::*; (
    input wire logic clock,
    input wire logic rstn,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    input wire logic vertical_sync,
    input wire logic horizontal_sync,
    input wire logic sensor_gate_pulse,
    output logic [NUM_REGS*DATA_W-1:0] reg_values,
    output logic [LINE_W-1:0] afe_operation_mode,
    output logic timing_core_reset_n,
    output logic oscillator_power_control
);
    localparam int NSYNC = 5;
    localparam int S_TOG = 4;
    localparam int S_STB = 3;
    localparam int S_VS = 2;
    localparam int S_HS = 1;
    localparam int S_SG = 0;
    // Idle levels: strobe and both syncs rest high, so no false edge follows reset
    localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h0E;

    logic rst_meta_r;
    logic rst_n_r;
    logic [ADDR_W-1:0] word_addr;
    logic [DATA_W-1:0] word_data;
    logic word_toggle;
    logic [NSYNC-1:0] pin_in;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [NSYNC-1:0] prev_r;
    logic stb_d2_r;
    logic tog_ev;
    logic stb_rise;
    logic vs_fall;
    logic hs_fall;
    logic sg_rise;
    logic wr_en_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] wr_data_r;
    logic [NUM_REGS:0] hit;
    logic [LINE_W-1:0] line_cnt_r;
    logic [LINE_W-1:0] update_line;
    logic update_inhibit;
    logic sg_armed_r;
    logic software_reset_bit_r;
    logic commit_stb;
    logic commit_line;
    logic commit_sg;

    // ========================================================
    // Reset release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ========================================================
    // Serial-clock domain
    srwp_shift_rx u_rx (
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe),
        .rst_n(rst_n_r),
        .word_addr_r(word_addr),
        .word_data_r(word_data),
        .word_toggle_r(word_toggle)
    );

    // ========================================================
    // Synchronisers for the word toggle and the strobe, sync and sensor-gate pins
    assign pin_in = {word_toggle, serial_load_strobe, vertical_sync, horizontal_sync, sensor_gate_pulse};

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            meta_r <= SYNC_IDLE;
            sync_r <= SYNC_IDLE;
            prev_r <= SYNC_IDLE;
            stb_d2_r <= 1'b1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
            stb_d2_r <= prev_r[S_STB];
        end
    end

    assign tog_ev = sync_r[S_TOG] ^ prev_r[S_TOG];
    // One stage later so the final word's toggle always lands first
    assign stb_rise = prev_r[S_STB] && !stb_d2_r;
    assign vs_fall = !sync_r[S_VS] && prev_r[S_VS];
    assign hs_fall = !sync_r[S_HS] && prev_r[S_HS];
    assign sg_rise = sync_r[S_SG] && !prev_r[S_SG];

    // ========================================================
    // Word capture; hand-off data is stable while the toggle is seen
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wr_en_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_en_r <= tog_ev;
            if (tog_ev) begin
                wr_addr_r <= word_addr;
                wr_data_r <= word_data;
            end
        end
    end

    // ========================================================
    // Update-line counter within the field
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            line_cnt_r <= '0;
        end else if (vs_fall) begin
            line_cnt_r <= '0;
        end else if (hs_fall) begin
            line_cnt_r <= line_cnt_r + 12'h001;
        end
    end

    assign update_line = {reg_values[A_UPD_HI*DATA_W +: DATA_W], reg_values[A_UPD_LO*DATA_W +: DATA_W]};
    assign update_inhibit = reg_values[A_INHIBIT*DATA_W];

    // ========================================================
    // Sensor-gate line tracking
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sg_armed_r <= 1'b0;
        end else if (sg_rise) begin
            sg_armed_r <= 1'b1;
        end else if (hs_fall) begin
            sg_armed_r <= 1'b0;
        end
    end

    // ========================================================
    // Software reset, a one-cycle pulse after the bit takes effect
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            software_reset_bit_r <= 1'b0;
        end else begin
            software_reset_bit_r <= reg_values[A_SWRST*DATA_W] && !software_reset_bit_r;
        end
    end

    // ========================================================
    // Commit events per group
    assign commit_stb = stb_rise;
    assign commit_line = hs_fall && (line_cnt_r == update_line) && !update_inhibit;
    assign commit_sg = hs_fall && sg_armed_r && !sg_rise;

    assign hit[NUM_REGS] = 1'b0;

    // ========================================================
    // Register entries: shadow, pending flag and effective value
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
        logic [DATA_W-1:0] shd_r;
        logic [DATA_W-1:0] act_r;
        logic pend_r;
        logic set_pend;
        logic commit;

        assign hit[i] = wr_en_r && (wr_addr_r == ADDR_W'(i));
        // Lower half of a wide register waits for its upper half
        assign set_pend = DBL_LO_MASK[i] ? hit[i+1] : hit[i];
        assign commit = STB_MASK[i] ? commit_stb : (SG_MASK[i] ? commit_sg : commit_line);

        always_ff @(posedge clock or negedge rst_n_r) begin
            if (!rst_n_r) begin
                shd_r <= srwp_default(ADDR_W'(i));
            end else if (software_reset_bit_r) begin
                shd_r <= srwp_default(ADDR_W'(i));
            end else if (hit[i]) begin
                shd_r <= wr_data_r;
            end
        end

        // A new write in the commit cycle stays pending: set wins
        always_ff @(posedge clock or negedge rst_n_r) begin
            if (!rst_n_r) begin
                pend_r <= 1'b0;
            end else if (software_reset_bit_r) begin
                pend_r <= 1'b0;
            end else if (set_pend) begin
                pend_r <= 1'b1;
            end else if (commit) begin
                pend_r <= 1'b0;
            end
        end

        always_ff @(posedge clock or negedge rst_n_r) begin
            if (!rst_n_r) begin
                act_r <= srwp_default(ADDR_W'(i));
            end else if (software_reset_bit_r) begin
                act_r <= srwp_default(ADDR_W'(i));
            end else if (commit && pend_r) begin
                act_r <= shd_r;
            end
        end

        assign reg_values[i*DATA_W +: DATA_W] = act_r;
    end

    // ========================================================
    // Decoded outputs, straight from the effective registers
    assign afe_operation_mode = {reg_values[A_OPR_HI*DATA_W +: DATA_W], reg_values[A_OPR_LO*DATA_W +: DATA_W]};
    assign timing_core_reset_n = reg_values[A_TGRST*DATA_W];
    assign oscillator_power_control = reg_values[A_OSC*DATA_W];

    // ========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n_r);

    AST_STB_COMMIT: assert property (
        commit_stb && g_reg[0].pend_r && !software_reset_bit_r |=> g_reg[0].act_r == $past(g_reg[0].shd_r))
        else $error("strobe group did not take the shadow value");

    AST_LOW_HALF_WAITS: assert property (
        hit[0] && !g_reg[0].pend_r && !hit[1] |=> !g_reg[0].pend_r)
        else $error("lower half became pending on its own");

    AST_HIGH_HALF_ARMS: assert property (
        hit[1] && !software_reset_bit_r |=> g_reg[0].pend_r && g_reg[1].pend_r)
        else $error("upper-half write did not arm both halves");

    AST_LINE_COMMIT: assert property (
        commit_line && g_reg[11].pend_r && !software_reset_bit_r |=> g_reg[11].act_r == $past(g_reg[11].shd_r))
        else $error("sync group missed its update line");

    AST_INHIBIT_HOLDS: assert property (
        update_inhibit && !software_reset_bit_r ##1 !software_reset_bit_r |-> $stable(g_reg[11].act_r))
        else $error("sync group changed while updates were inhibited");

    AST_SG_IGNORES_STB: assert property (
        commit_stb && !commit_sg && !software_reset_bit_r |=> $stable(g_reg[62].act_r))
        else $error("substrate group changed on strobe edge");

    AST_SOFTWARE_RESET_BIT: assert property (
        software_reset_bit_r |=> g_reg[0].act_r == 6'h10 && g_reg[3].act_r == 6'h01 && !g_reg[0].pend_r)
        else $error("software reset did not restore defaults");

    AST_LINE_COUNT: assert property (
        hs_fall && !vs_fall |=> line_cnt_r == $past(line_cnt_r) + 12'h001)
        else $error("update-line counter did not advance");

    AST_WORD_LANDS: assert property (
        tog_ev |=> wr_en_r ##1 !wr_en_r || tog_ev)
        else $error("received word not written once");

    // ========================================================
    // Group separation and commit details
    AST_SG_COMMIT: assert property (
        commit_sg && g_reg[62].pend_r && !software_reset_bit_r |=> g_reg[62].act_r == $past(g_reg[62].shd_r))
        else $error("substrate group missed the line after the sensor gate");

    AST_SG_IGNORES_LINE: assert property (
        commit_line && !commit_sg && !software_reset_bit_r |=> $stable(g_reg[62].act_r))
        else $error("substrate group changed on the update line");

    AST_LINE_IGNORES_STB: assert property (
        commit_stb && !commit_line && !software_reset_bit_r |=> $stable(g_reg[11].act_r))
        else $error("sync group changed on strobe edge");

    AST_WIDE_BOTH_HALVES: assert property (
        commit_stb && g_reg[1].pend_r && !software_reset_bit_r |=>
            g_reg[0].act_r == $past(g_reg[0].shd_r) && g_reg[1].act_r == $past(g_reg[1].shd_r))
        else $error("wide register halves did not commit together");

    AST_LOW_HALF_HOLDS: assert property (
        hit[0] && !hit[1] && !g_reg[0].pend_r && !software_reset_bit_r |=> $stable(g_reg[0].act_r))
        else $error("lower-half write changed the effective value");

    AST_LINE_RESTART: assert property (
        vs_fall |=> line_cnt_r == 12'h000)
        else $error("line count not restarted by vertical sync");

    AST_LINE_WAITS: assert property (
        hs_fall && (line_cnt_r != update_line) && !software_reset_bit_r |=> $stable(g_reg[11].act_r))
        else $error("sync group committed off its update line");

    AST_INHIBIT_SPARES_STB: assert property (
        update_inhibit && commit_stb && g_reg[23].pend_r && !software_reset_bit_r |=>
            g_reg[23].act_r == $past(g_reg[23].shd_r))
        else $error("inhibit held back the strobe group");

    AST_SWRST_SELF_CLEARS: assert property (
        software_reset_bit_r |=> g_reg[23].act_r == 6'h00)
        else $error("software reset bit did not return to zero");

    AST_SWRST_SHADOW: assert property (
        software_reset_bit_r |=> g_reg[11].shd_r == 6'h00 && !g_reg[11].pend_r)
        else $error("software reset left a pending write");

    AST_SHADOW_TAKES: assert property (
        hit[11] && !software_reset_bit_r |=> g_reg[11].shd_r == $past(wr_data_r))
        else $error("received word not stored in its shadow");

    AST_SG_ARMS: assert property (
        sg_rise |=> sg_armed_r)
        else $error("sensor gate did not arm the substrate commit");

    // Hand-off words must be settled when the toggle is seen
    AST_HANDOFF_STABLE: assert property (
        tog_ev |-> $stable(word_addr) && $stable(word_data))
        else $error("hand-off word moved while being captured");

    COV_STB_COMMIT: cover property (commit_stb && g_reg[0].pend_r);
    COV_LINE_COMMIT: cover property (commit_line && g_reg[11].pend_r);
    COV_SG_COMMIT: cover property (commit_sg && g_reg[62].pend_r);
    COV_SOFTWARE_RESET_BIT: cover property (software_reset_bit_r);
endmodule // srwp_top

// ===== verif/srwp_host_model.sv
// Host model that frames and shifts serial register writes
`timescale 1ns/1ps
module srwp_host_model import srwp_pkg::*; (
    output logic serial_clock,
    output logic serial_data,
    output logic serial_load_strobe
);
    // ============================================================
    // Idle levels: clock parked low, strobe high
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        serial_load_strobe = 1'b1;
    end

    // ============================================================
    // Bit shifting, 64 ns serial period
    task automatic shift(input logic b);
        serial_data = b;
        #32 serial_clock = 1'b1;
        #32 serial_clock = 1'b0;
    endtask

    // Word k of data sits at bits [6k+5:6k]; nbits counts data bits after the address
    task automatic send(input logic [ADDR_W-1:0] addr, input logic [47:0] data, input int nbits);
        serial_load_strobe = 1'b0;
        #32;
        for (int i = 0; i < ADDR_W; i++) shift(addr[i]);
        for (int i = 0; i < nbits; i++) shift(data[i]);
        // Margin so the last word joins the strobe commit
        #200 serial_load_strobe = 1'b1;
        // Released line no longer holds the last bit
        serial_data = ~serial_data;
        #64;
    endtask
endmodule // srwp_host_model

// ===== verif/tb.sv
// Testbench: serial writes, sync events and register value checks
`timescale 1ns/1ps
module tb import srwp_pkg::*; ;
    localparam int CEIL = 6000;
    logic clock;
    logic rstn;
    logic vertical_sync;
    logic horizontal_sync;
    logic sensor_gate_pulse;
    wire logic serial_clock;
    wire logic serial_data;
    wire logic serial_load_strobe;
    logic [NUM_REGS*DATA_W-1:0] reg_values;
    logic [LINE_W-1:0] afe_operation_mode;
    logic timing_core_reset_n;
    logic oscillator_power_control;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    srwp_top dut (.clock(clock), .rstn(rstn), .serial_clock(serial_clock), .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe), .vertical_sync(vertical_sync),
        .horizontal_sync(horizontal_sync), .sensor_gate_pulse(sensor_gate_pulse), .reg_values(reg_values),
        .afe_operation_mode(afe_operation_mode), .timing_core_reset_n(timing_core_reset_n),
        .oscillator_power_control(oscillator_power_control));
    srwp_host_model host (.serial_clock(serial_clock), .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe));

    // ============================================================
    // Clock, time limit and verdict
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic results();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            n_fail++;
            results();
        end
    end

    // ============================================================
    // Helpers
    task automatic wclk(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic chk_val(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [5:0] exp);
        checks_done++;
        if (reg_values[a*6 +: 6] !== exp) begin
            n_fail++;
            $display("[FAIL] reg %h expected %h seen %h", a, exp, reg_values[a*6 +: 6]);
        end
    endtask

    function automatic logic [5:0] dflt(input logic [ADDR_W-1:0] a);
        case (a)
            10'h000: return 6'h10;
            10'h002: return 6'h05;
            10'h003: return 6'h01;
            10'h005: return 6'h02;
            10'h021: return 6'h01;
            10'h031: return 6'h01;
            10'h032: return 6'h02;
            10'h033: return 6'h01;
            default: return 6'h00;
        endcase
    endfunction

    task automatic chk_defaults();
        for (int a = 0; a < NUM_REGS; a++) chk_reg(10'(a), dflt(10'(a)));
        chk_val("afe mode", 12'h010, afe_operation_mode);
        chk_val("osc ctl", 12'h001, {11'h000, oscillator_power_control});
        chk_val("core reset", 12'h000, {11'h000, timing_core_reset_n});
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [47:0] d, input int nbits);
        host.send(a, d, nbits);
        wclk(10);
    endtask

    // Sync falls held 4 clocks to clear the synchronisers
    task automatic vsync_fall();
        vertical_sync = 1'b0;
        wclk(4);
        vertical_sync = 1'b1;
        wclk(4);
    endtask

    task automatic hsync_fall(input int n);
        repeat (n) begin
            horizontal_sync = 1'b0;
            wclk(4);
            horizontal_sync = 1'b1;
            wclk(4);
        end
    endtask

    // ============================================================
    // Scenarios
    task automatic t_strobe();
        wr(A_TGRST, 48'h25, 6);
        chk_reg(A_TGRST, 6'h25);
        chk_val("core reset", 12'h001, {11'h000, timing_core_reset_n});
        wr(A_OSC, 48'h3E, 6);
        chk_val("osc ctl", 12'h000, {11'h000, oscillator_power_control});
        // Second word cut after 3 bits
        wr(A_TGRST, 48'h140, 9);
        chk_val("core reset", 12'h000, {11'h000, timing_core_reset_n});
        chk_reg(10'h02A, 6'h00);
        $display("strobe group test done");
    endtask

    task automatic t_wide();
        wr(A_OPR_LO, 48'h56A, 12);
        chk_val("afe mode", 12'h56A, afe_operation_mode);
        wr(A_OPR_LO, 48'h3F, 6);
        chk_val("afe mode", 12'h56A, afe_operation_mode);
        wr(A_OPR_HI, 48'h07, 6);
        chk_val("afe high", 12'h007, {6'h00, afe_operation_mode[11:6]});
        $display("wide register test done");
    endtask

    task automatic t_sync();
        wr(A_UPD_LO, 48'h2, 12);
        vsync_fall();
        hsync_fall(1);
        chk_reg(A_UPD_LO, 6'h02);
        wr(10'h00B, 48'h334A1, 18);
        chk_reg(10'h00B, 6'h00);
        vsync_fall();
        hsync_fall(2);
        chk_reg(10'h00B, 6'h00);
        hsync_fall(1);
        chk_reg(10'h00B, 6'h21);
        chk_reg(10'h00C, 6'h12);
        chk_reg(10'h00D, 6'h33);
        $display("sync update test done");
    endtask

    task automatic t_gate();
        wr(10'h03E, 48'hB5C, 12);
        vsync_fall();
        hsync_fall(3);
        chk_reg(10'h03E, 6'h00);
        sensor_gate_pulse = 1'b1;
        wclk(4);
        sensor_gate_pulse = 1'b0;
        hsync_fall(1);
        chk_reg(10'h03E, 6'h1C);
        chk_reg(10'h03F, 6'h2D);
        $display("sensor gate test done");
    endtask

    task automatic t_inhibit();
        wr(A_INHIBIT, 48'h01, 6);
        vsync_fall();
        hsync_fall(3);
        chk_reg(A_INHIBIT, 6'h01);
        wr(10'h00B, 48'h3C, 6);
        vsync_fall();
        hsync_fall(4);
        chk_reg(10'h00B, 6'h21);
        $display("update inhibit test done");
    endtask

    task automatic t_swrst();
        wr(A_SWRST, 48'h01, 6);
        chk_defaults();
        $display("software reset test done");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        vertical_sync = 1'b1;
        horizontal_sync = 1'b1;
        sensor_gate_pulse = 1'b0;
        repeat (6) @(posedge clock);
        #2 rstn = 1'b1;
        wclk(6);
        chk_defaults();
        $display("reset value test done");
        t_strobe();
        t_wide();
        t_sync();
        t_gate();
        t_inhibit();
        t_swrst();
        results();
    end
endmodule // tb
